// ==== pdc_chan_ctr.sv ====
`timescale 1ns/100ps
module dma_chan_ctr
  import dma_chan_pkg::*;
#(
  parameter int unsigned CNT_W = CNT_WIDTH
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  // Register writes
  input  wire logic             i_wr_ptr,
  input  wire logic             i_wr_cnt,
  input  wire logic             i_wr_nptr,
  input  wire logic             i_wr_ncnt,
  input  wire logic [31:0]      i_wdata,
  // Transfer progress
  input  wire logic             i_step,
  input  wire logic [1:0]       i_size,
  // Channel state
  output logic      [31:0]      o_ptr,
  output logic      [CNT_W-1:0] o_cnt,
  output logic      [31:0]      o_nptr,
  output logic      [CNT_W-1:0] o_ncnt,
  output logic                  o_end_evt
);

  if (CNT_W < 1 || CNT_W > DATA_W) begin : g_bad_width
    $error("Counter width must lie between 1 and the data width.");
  end

  typedef struct packed {
    logic [31:0]      ptr;
    logic [CNT_W-1:0] cnt;
    logic [31:0]      nptr;
    logic [CNT_W-1:0] ncnt;
  } chan_state_s;

  chan_state_s q;
  chan_state_s d;
  logic        end_evt;
  logic        quiet;

  // A software write lands after the step and the reload, so a pointer or count
  // reprogrammed mid-buffer is taken as the new truth.
  always_comb begin
    d       = q;
    end_evt = 1'b0;
    if (i_step && q.cnt != '0) begin
      d.ptr   = q.ptr + {29'h0, step_bytes(i_size)};
      d.cnt   = q.cnt - CNT_W'(1);
      end_evt = (q.cnt == CNT_W'(1));
    end
    if (d.cnt == '0 && q.ncnt != '0 && !i_wr_cnt && !i_wr_ptr) begin
      d.ptr  = q.nptr;
      d.cnt  = q.ncnt;
      d.ncnt = '0;
    end
    if (i_wr_ptr) begin
      d.ptr = i_wdata;
    end
    if (i_wr_cnt) begin
      d.cnt = i_wdata[CNT_W-1:0];
    end
    if (i_wr_nptr) begin
      d.nptr = i_wdata;
    end
    if (i_wr_ncnt) begin
      d.ncnt = i_wdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{ptr: REG_RESET, cnt: '0, nptr: REG_RESET, ncnt: '0};
    end else begin
      q <= d;
    end
  end

  assign o_ptr     = q.ptr;
  assign o_cnt     = q.cnt;
  assign o_nptr    = q.nptr;
  assign o_ncnt    = q.ncnt;
  assign o_end_evt = end_evt;
  assign quiet     = !(i_wr_ptr || i_wr_cnt || i_wr_nptr || i_wr_ncnt);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  step_adv_a: assert property (
    i_step && quiet && q.cnt > CNT_W'(1) |=>
      q.ptr == $past(q.ptr) + {29'h0, step_bytes($past(i_size))} &&
      q.cnt == $past(q.cnt) - CNT_W'(1))
    else $error("Pointer or count did not advance by one transfer.");

  chain_load_a: assert property (
    i_step && quiet && q.cnt == CNT_W'(1) && q.ncnt != '0 |=>
      q.cnt == $past(q.ncnt) && q.ptr == $past(q.nptr) && q.ncnt == '0)
    else $error("Next buffer was not loaded when the count ran out.");

  idle_hold_a: assert property (
    quiet && q.cnt == '0 && q.ncnt == '0 |=> q.cnt == '0 && $stable(q.ptr))
    else $error("Exhausted channel moved on its own.");

endmodule // dma_chan_ctr

// ==== pdc_chan_partner.sv ====
`timescale 1ns/100ps
module dma_chan_partner (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Bench commands
  input  wire logic       i_rx_want,
  input  wire logic       i_tx_want,
  input  wire logic [3:0] i_delay,
  // Device side
  input  wire logic       i_mem_req,
  output logic            o_rx_ready,
  output logic            o_tx_ready,
  output logic            o_mem_done
);
  logic [3:0] wait_q;

  // The peripheral holds its trigger as a level while it has data to move.
  assign o_rx_ready = i_rx_want;
  assign o_tx_ready = i_tx_want;

  // One done pulse per request after a chosen wait, so slow memory is exercised too.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_q     <= 4'h0;
      o_mem_done <= 1'b0;
    end else if (i_mem_req && !o_mem_done) begin
      o_mem_done <= (wait_q == 4'h0);
      wait_q     <= (wait_q == 4'h0) ? i_delay : wait_q - 4'h1;
    end else begin
      o_mem_done <= 1'b0;
      wait_q     <= i_delay;
    end
  end
endmodule // dma_chan_partner

// ==== pdc_chan_pkg.sv ====
package dma_chan_pkg;

  // Register window, decoded on the low address bits of the peripheral space.
  localparam int unsigned OFS_W          = 9;
  localparam logic [8:0]  OFS_RX_ADDR    = 9'h100;
  localparam logic [8:0]  OFS_RX_CNT     = 9'h104;
  localparam logic [8:0]  OFS_TX_ADDR    = 9'h108;
  localparam logic [8:0]  OFS_TX_CNT     = 9'h10C;
  localparam logic [8:0]  OFS_RX_NADDR   = 9'h110;
  localparam logic [8:0]  OFS_RX_NCNT    = 9'h114;
  localparam logic [8:0]  OFS_TX_NADDR   = 9'h118;
  localparam logic [8:0]  OFS_TX_NCNT    = 9'h11C;
  localparam logic [8:0]  OFS_CTL        = 9'h120;
  localparam logic [8:0]  OFS_STAT       = 9'h124;
  localparam logic [8:0]  OFS_IRQ_STAT   = 9'h128;
  localparam logic [8:0]  OFS_IRQ_MASK   = 9'h12C;

  // Widths and reset values.
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned CNT_WIDTH      = 16;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  localparam logic [3:0]  IRQ_RESET      = 4'h0;

  // Control and transfer status bit positions.
  localparam int unsigned CTL_RX_EN_BIT  = 0;
  localparam int unsigned CTL_RX_DIS_BIT = 1;
  localparam int unsigned CTL_TX_EN_BIT  = 8;
  localparam int unsigned CTL_TX_DIS_BIT = 9;
  localparam int unsigned STAT_RX_EN_BIT = 0;
  localparam int unsigned STAT_TX_EN_BIT = 8;

  // Interrupt status and mask layout.
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_RX_END     = 0;
  localparam int unsigned IRQ_RX_FULL    = 1;
  localparam int unsigned IRQ_TX_END     = 2;
  localparam int unsigned IRQ_TX_EMPTY   = 3;

  // Transfer sizes.
  localparam logic [1:0]  SIZE_BYTE      = 2'h0;
  localparam logic [1:0]  SIZE_HALF      = 2'h1;
  localparam logic [1:0]  SIZE_WORD      = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RX   = 2'b01,
    ST_TX   = 2'b10
  } xfer_state_e;

  function automatic logic [2:0] step_bytes(input logic [1:0] size);
    unique case (size)
      SIZE_BYTE: step_bytes = 3'h1;
      SIZE_HALF: step_bytes = 3'h2;
      default:   step_bytes = 3'h4;
    endcase
  endfunction

endpackage

// ==== pdc_chan_top.sv ====
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Function
// - Receive count holds the receive transfers still due into the current buffer.
// - Transmit pointer gives the memory address of the next transmit fetch.
// - Transmit count sizes the transfer; at zero no transmit data moves.
// - Next receive pointer becomes the receive address once the current buffer fills.
// - Next receive count sizes the next receive buffer of the chain.
// - Next transmit pointer becomes the transmit address once the current buffer empties.
// - Next transmit count sizes the next transmit buffer of the chain.
// - Control bit 0 enables receive unless bit 1 is set; zeros do nothing.
// - Control bit 1 disables receive transfer requests.
// - Control bit 8 enables transmit transfer requests.
// - Control bit 9 disables transmit transfer requests.
// - Status bit 0 reads the receive enable state.
// - Status bit 8 reads the transmit enable state.
// - Each transfer adds 1, 2 or 4 to the pointer and decrements the count.
// - Count at zero loads next pointer and count, then clears next count.
// - End flag when a transfer runs the current count down to zero; full or empty when both counts are zero.
// - Writing a direction's current or next count clears its end flag.
module dma_chan_top
  import dma_chan_pkg::*;
(
  // Clock and reset
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_NRST,
  // AHB-Lite slave
  input  wire logic              I_HSEL,
  input  wire logic [31:0]       I_HADDR,
  input  wire logic [1:0]        I_HTRANS,
  input  wire logic              I_HWRITE,
  input  wire logic [2:0]        I_HSIZE,
  input  wire logic              I_HREADY,
  input  wire logic [31:0]       I_HWDATA,
  output logic      [31:0]       O_HRDATA,
  output logic                   O_HREADYOUT,
  output logic                   O_HRESP,
  // Peripheral triggers
  input  wire logic              I_RX_READY,
  input  wire logic              I_TX_READY,
  input  wire logic [1:0]        I_XFER_SIZE,
  // Memory transfer port
  output logic                   O_MEM_REQ,
  output logic                   O_MEM_WRITE,
  output logic      [31:0]       O_MEM_ADDR,
  output logic      [1:0]        O_MEM_SIZE,
  input  wire logic              I_MEM_DONE,
  // Buffer flags and interrupt
  output logic                   O_RX_END,
  output logic                   O_RX_FULL,
  output logic                   O_TX_END,
  output logic                   O_TX_EMPTY,
  output logic                   O_IRQ
);

  typedef struct packed {
    xfer_state_e      state;
    logic             rx_en;
    logic             tx_en;
    logic             wr_pend;
    logic [OFS_W-1:0] wr_ofs;
    logic [31:0]      rdata;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0]      mem_addr;
    logic             mem_write;
    logic [1:0]       mem_size;
  } top_state_s;

  top_state_s           q;
  top_state_s           d;

  logic                 addr_take;
  logic [OFS_W-1:0]     addr_ofs;
  logic                 wr_rx_ptr;
  logic                 wr_rx_cnt;
  logic                 wr_rx_nptr;
  logic                 wr_rx_ncnt;
  logic                 wr_tx_ptr;
  logic                 wr_tx_cnt;
  logic                 wr_tx_nptr;
  logic                 wr_tx_ncnt;
  logic                 rx_step;
  logic                 tx_step;
  logic                 rx_go;
  logic                 tx_go;
  logic                 rx_end_evt;
  logic                 tx_end_evt;
  logic                 rx_full_lvl;
  logic                 tx_empty_lvl;
  logic [IRQ_W-1:0]     irq_set;
  logic [IRQ_W-1:0]     irq_clr;
  logic [31:0]          rx_ptr;
  logic [31:0]          rx_nptr;
  logic [31:0]          tx_ptr;
  logic [31:0]          tx_nptr;
  logic [CNT_WIDTH-1:0] rx_cnt;
  logic [CNT_WIDTH-1:0] rx_ncnt;
  logic [CNT_WIDTH-1:0] tx_cnt;
  logic [CNT_WIDTH-1:0] tx_ncnt;

  function automatic logic [31:0] zext(input logic [CNT_WIDTH-1:0] cnt);
    zext = {{(DATA_W - CNT_WIDTH){1'b0}}, cnt};
  endfunction

  function automatic logic wr_hit(input logic pend, input logic [OFS_W-1:0] ofs,
                                  input logic [OFS_W-1:0] target);
    wr_hit = pend && (ofs == target);
  endfunction

  // Writes are applied in the data phase, where the word finally stands on the bus.
  assign addr_take  = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign addr_ofs   = I_HADDR[OFS_W-1:0];
  assign wr_rx_ptr  = wr_hit(q.wr_pend, q.wr_ofs, OFS_RX_ADDR);
  assign wr_rx_cnt  = wr_hit(q.wr_pend, q.wr_ofs, OFS_RX_CNT);
  assign wr_rx_nptr = wr_hit(q.wr_pend, q.wr_ofs, OFS_RX_NADDR);
  assign wr_rx_ncnt = wr_hit(q.wr_pend, q.wr_ofs, OFS_RX_NCNT);
  assign wr_tx_ptr  = wr_hit(q.wr_pend, q.wr_ofs, OFS_TX_ADDR);
  assign wr_tx_cnt  = wr_hit(q.wr_pend, q.wr_ofs, OFS_TX_CNT);
  assign wr_tx_nptr = wr_hit(q.wr_pend, q.wr_ofs, OFS_TX_NADDR);
  assign wr_tx_ncnt = wr_hit(q.wr_pend, q.wr_ofs, OFS_TX_NCNT);

  dma_chan_ctr #(
    .CNT_W     (CNT_WIDTH)
  ) u_rx_chan (
    .i_clk     (I_SYS_CLK),
    .i_nrst    (I_NRST),
    .i_wr_ptr  (wr_rx_ptr),
    .i_wr_cnt  (wr_rx_cnt),
    .i_wr_nptr (wr_rx_nptr),
    .i_wr_ncnt (wr_rx_ncnt),
    .i_wdata   (I_HWDATA),
    .i_step    (rx_step),
    .i_size    (q.mem_size),
    .o_ptr     (rx_ptr),
    .o_cnt     (rx_cnt),
    .o_nptr    (rx_nptr),
    .o_ncnt    (rx_ncnt),
    .o_end_evt (rx_end_evt)
  );

  dma_chan_ctr #(
    .CNT_W     (CNT_WIDTH)
  ) u_tx_chan (
    .i_clk     (I_SYS_CLK),
    .i_nrst    (I_NRST),
    .i_wr_ptr  (wr_tx_ptr),
    .i_wr_cnt  (wr_tx_cnt),
    .i_wr_nptr (wr_tx_nptr),
    .i_wr_ncnt (wr_tx_ncnt),
    .i_wdata   (I_HWDATA),
    .i_step    (tx_step),
    .i_size    (q.mem_size),
    .o_ptr     (tx_ptr),
    .o_cnt     (tx_cnt),
    .o_nptr    (tx_nptr),
    .o_ncnt    (tx_ncnt),
    .o_end_evt (tx_end_evt)
  );

  // An empty channel never raises a request, so a zero count stops the direction.
  assign rx_go        = q.rx_en && (rx_cnt != '0) && I_RX_READY;
  assign tx_go        = q.tx_en && (tx_cnt != '0) && I_TX_READY;
  assign rx_step      = (q.state == ST_RX) && I_MEM_DONE;
  assign tx_step      = (q.state == ST_TX) && I_MEM_DONE;
  assign rx_full_lvl  = (rx_cnt == '0) && (rx_ncnt == '0);
  assign tx_empty_lvl = (tx_cnt == '0) && (tx_ncnt == '0);

  always_comb begin
    irq_set               = '0;
    irq_set[IRQ_RX_END]   = rx_end_evt;
    irq_set[IRQ_RX_FULL]  = rx_full_lvl;
    irq_set[IRQ_TX_END]   = tx_end_evt;
    irq_set[IRQ_TX_EMPTY] = tx_empty_lvl;
    irq_clr               = '0;
    if (wr_hit(q.wr_pend, q.wr_ofs, OFS_IRQ_STAT)) begin
      irq_clr = I_HWDATA[IRQ_W-1:0];
    end
    if (wr_rx_cnt || wr_rx_ncnt) begin
      irq_clr[IRQ_RX_END] = 1'b1;
    end
    if (wr_tx_cnt || wr_tx_ncnt) begin
      irq_clr[IRQ_TX_END] = 1'b1;
    end
  end

  always_comb begin
    d          = q;
    d.wr_pend  = addr_take && I_HWRITE;
    d.irq_stat = (q.irq_stat & ~irq_clr) | irq_set;

    if (addr_take) begin
      d.wr_ofs = addr_ofs;
    end
    if (addr_take && !I_HWRITE) begin
      unique case (addr_ofs)
        OFS_RX_ADDR:  d.rdata = rx_ptr;
        OFS_RX_CNT:   d.rdata = zext(rx_cnt);
        OFS_TX_ADDR:  d.rdata = tx_ptr;
        OFS_TX_CNT:   d.rdata = zext(tx_cnt);
        OFS_RX_NADDR: d.rdata = rx_nptr;
        OFS_RX_NCNT:  d.rdata = zext(rx_ncnt);
        OFS_TX_NADDR: d.rdata = tx_nptr;
        OFS_TX_NCNT:  d.rdata = zext(tx_ncnt);
        OFS_STAT: begin
          d.rdata                 = REG_RESET;
          d.rdata[STAT_RX_EN_BIT] = q.rx_en;
          d.rdata[STAT_TX_EN_BIT] = q.tx_en;
        end
        OFS_IRQ_STAT: d.rdata = {{(DATA_W - IRQ_W){1'b0}}, q.irq_stat};
        OFS_IRQ_MASK: d.rdata = {{(DATA_W - IRQ_W){1'b0}}, q.irq_mask};
        default:      d.rdata = REG_RESET;
      endcase
    end

    // Enables and disables are commands; a zero bit leaves the state alone.
    if (wr_hit(q.wr_pend, q.wr_ofs, OFS_CTL)) begin
      if (I_HWDATA[CTL_RX_DIS_BIT]) begin
        d.rx_en = 1'b0;
      end else if (I_HWDATA[CTL_RX_EN_BIT]) begin
        d.rx_en = 1'b1;
      end
      if (I_HWDATA[CTL_TX_DIS_BIT]) begin
        d.tx_en = 1'b0;
      end else if (I_HWDATA[CTL_TX_EN_BIT]) begin
        d.tx_en = 1'b1;
      end
    end
    if (wr_hit(q.wr_pend, q.wr_ofs, OFS_IRQ_MASK)) begin
      d.irq_mask = I_HWDATA[IRQ_W-1:0];
    end

    // Receive is served ahead of transmit. A transfer under way always completes,
    // even if its direction is disabled meanwhile, so memory never sees half a move.
    unique case (q.state)
      ST_IDLE: begin
        if (rx_go) begin
          d.state     = ST_RX;
          d.mem_addr  = rx_ptr;
          d.mem_write = 1'b1;
          d.mem_size  = I_XFER_SIZE;
        end else if (tx_go) begin
          d.state     = ST_TX;
          d.mem_addr  = tx_ptr;
          d.mem_write = 1'b0;
          d.mem_size  = I_XFER_SIZE;
        end
      end
      ST_RX, ST_TX: begin
        if (I_MEM_DONE) begin
          d.state = ST_IDLE;
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      q <= '{state:     ST_IDLE,
             rx_en:     1'b0,
             tx_en:     1'b0,
             wr_pend:   1'b0,
             wr_ofs:    '0,
             rdata:     REG_RESET,
             irq_stat:  IRQ_RESET,
             irq_mask:  IRQ_RESET,
             mem_addr:  REG_RESET,
             mem_write: 1'b0,
             mem_size:  SIZE_BYTE};
    end else begin
      q <= d;
    end
  end

  assign O_HRDATA    = q.rdata;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign O_MEM_REQ   = (q.state != ST_IDLE);
  assign O_MEM_WRITE = q.mem_write;
  assign O_MEM_ADDR  = q.mem_addr;
  assign O_MEM_SIZE  = q.mem_size;
  assign O_RX_END    = q.irq_stat[IRQ_RX_END];
  assign O_RX_FULL   = q.irq_stat[IRQ_RX_FULL];
  assign O_TX_END    = q.irq_stat[IRQ_TX_END];
  assign O_TX_EMPTY  = q.irq_stat[IRQ_TX_EMPTY];
  assign O_IRQ       = |(q.irq_stat & q.irq_mask);

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_NRST);

  sequence ctl_wr_s;
    q.wr_pend && (q.wr_ofs == OFS_CTL);
  endsequence

  sequence stat_rd_s;
    addr_take && !I_HWRITE && (addr_ofs == OFS_STAT);
  endsequence

  rx_enable_a: assert property (
    ctl_wr_s ##0 (I_HWDATA[CTL_RX_EN_BIT] && !I_HWDATA[CTL_RX_DIS_BIT]) |=> q.rx_en)
    else $error("Receive enable command was not taken.");

  rx_disable_a: assert property (
    ctl_wr_s ##0 I_HWDATA[CTL_RX_DIS_BIT] |=> !q.rx_en)
    else $error("Receive disable command was not taken.");

  ctl_zero_a: assert property (
    ctl_wr_s ##0 (I_HWDATA[CTL_RX_EN_BIT] == 1'b0 && I_HWDATA[CTL_RX_DIS_BIT] == 1'b0 &&
                  I_HWDATA[CTL_TX_EN_BIT] == 1'b0 && I_HWDATA[CTL_TX_DIS_BIT] == 1'b0)
      |=> $stable(q.rx_en) && $stable(q.tx_en))
    else $error("A zero control word changed an enable.");

  tx_enable_a: assert property (
    ctl_wr_s ##0 (I_HWDATA[CTL_TX_EN_BIT] && !I_HWDATA[CTL_TX_DIS_BIT]) |=> q.tx_en)
    else $error("Transmit enable command was not taken.");

  tx_disable_a: assert property (
    ctl_wr_s ##0 I_HWDATA[CTL_TX_DIS_BIT] |=> !q.tx_en)
    else $error("Transmit disable command was not taken.");

  tx_both_a: assert property (
    ctl_wr_s ##0 (I_HWDATA[CTL_TX_DIS_BIT] && I_HWDATA[CTL_TX_EN_BIT]) |=> !q.tx_en)
    else $error("Transmit enable beat disable in one write.");

  stat_read_a: assert property (
    stat_rd_s |=> O_HRDATA[STAT_RX_EN_BIT] == $past(q.rx_en) &&
                  O_HRDATA[STAT_TX_EN_BIT] == $past(q.tx_en) &&
                  O_HRDATA[7:1] == 7'h00)
    else $error("Transfer status read does not match the enables.");

  zero_stop_a: assert property (
    q.state == ST_IDLE && tx_cnt == '0 |=> q.state != ST_TX)
    else $error("Transmit started with a zero count.");

  rx_first_a: assert property (
    q.state == ST_IDLE && rx_go && tx_go |=> q.state == ST_RX)
    else $error("Transmit was served ahead of receive.");

  tx_addr_a: assert property (
    q.state == ST_IDLE && !rx_go && tx_go |=> O_MEM_REQ && !O_MEM_WRITE &&
                                              O_MEM_ADDR == $past(tx_ptr))
    else $error("Transmit fetch does not use the transmit pointer.");

  req_hold_a: assert property (
    O_MEM_REQ && !I_MEM_DONE |=> O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WRITE))
    else $error("Memory request dropped before completion.");

  end_clear_a: assert property (
    (wr_rx_cnt || wr_rx_ncnt) && !rx_end_evt |=> !O_RX_END)
    else $error("Receive end flag survived a count write.");

  end_set_a: assert property (
    tx_end_evt |=> O_TX_END)
    else $error("Transmit end flag not raised when the count ran out.");

  full_flag_a: assert property (
    rx_full_lvl |=> O_RX_FULL ##1 (O_RX_FULL || !rx_full_lvl))
    else $error("Receive full flag not raised with both counts at zero.");

  irq_out_a: assert property (
    tx_end_evt && q.irq_mask[IRQ_TX_END] && !wr_hit(q.wr_pend, q.wr_ofs, OFS_IRQ_MASK)
      |=> O_IRQ)
    else $error("Unmasked flag did not raise the interrupt.");

endmodule // dma_chan_top

// ==== peripheral_dma_channel_regs_bench.sv ====
`timescale 1ns/100ps
module peripheral_dma_channel_regs_bench;
  import dma_chan_pkg::*;
  logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        rx_want = 1'b0, tx_want = 1'b0;
  logic        hready, hresp, rx_rdy, tx_rdy, done, req, mwr, irq;
  logic        rx_end, rx_full, tx_end, tx_empty;
  logic [1:0]  htrans = 2'h0, xsize = 2'h0, msize;
  logic [3:0]  dly = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, maddr, rd, a, b, d, s;
  int          seed = 7791, errors = 0, n_tests = 0, cycles = 0, ndone = 0;
  logic [31:0] exp_q[$];
  logic [11:0] ctl_tab [8] = '{12'h101, 12'h000, 12'h003, 12'h300,
                               12'h002, 12'h100, 12'h201, 12'h202};
  logic [11:0] st_tab  [8] = '{12'h101, 12'h101, 12'h100, 12'h000,
                               12'h000, 12'h100, 12'h001, 12'h000};

  always #10 clk = ~clk;

  dma_chan_top dma_chan_top_i (
    .I_SYS_CLK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HREADY(hready), .I_HWDATA(hwdata),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_RX_READY(rx_rdy),
    .I_TX_READY(tx_rdy), .I_XFER_SIZE(xsize), .O_MEM_REQ(req), .O_MEM_WRITE(mwr),
    .O_MEM_ADDR(maddr), .O_MEM_SIZE(msize), .I_MEM_DONE(done), .O_RX_END(rx_end),
    .O_RX_FULL(rx_full), .O_TX_END(tx_end), .O_TX_EMPTY(tx_empty), .O_IRQ(irq));

  dma_chan_partner dma_chan_partner_i (
    .i_clk(clk), .i_nrst(nrst), .i_rx_want(rx_want), .i_tx_want(tx_want), .i_delay(dly),
    .i_mem_req(req), .o_rx_ready(rx_rdy), .o_tx_ready(tx_rdy), .o_mem_done(done));

  function automatic logic [31:0] stepb(input logic [1:0] sz);
    return (sz == 2'h0) ? 32'h1 : (sz == 2'h1) ? 32'h2 : 32'h4;
  endfunction

  task automatic close_out();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The leading edge leaves an idle cycle, so a read always sees the previous write.
  task automatic bus(input logic w, input logic [8:0] ofs, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {23'h0, ofs};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [8:0] ofs, input logic [31:0] wd);
    bus(1'b1, ofs, wd);
  endtask

  task automatic rdc(input logic [8:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    chk32(rd, exp);
  endtask

  task automatic xfer(input logic rx, input int n);
    ndone = 0;
    dly <= 4'($unsigned($random(seed)) % 5);
    if (rx) rx_want <= 1'b1;
    else tx_want <= 1'b1;
    while (ndone < n) @(posedge clk);
    rx_want <= 1'b0;
    tx_want <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Every completed memory transfer is checked against the expected address list.
  always @(posedge clk) begin
    cycles++;
    if (req === 1'b1 && done === 1'b1) begin
      chk32(maddr, exp_q.pop_front());
      chk32({30'h0, msize}, {30'h0, xsize});
      chk1(mwr, rx_want);
      ndone++;
    end
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (logic [8:0] k = 9'h100; k < 9'h128; k += 9'h004) rdc(k, 32'h0);
    rdc(OFS_IRQ_STAT, 32'hA);
    wr(9'h130, 32'hFFFF_FFFF);
    rdc(9'h130, 32'h0);
    for (logic [8:0] k = 9'h100; k < 9'h120; k += 9'h004) begin
      d = $random(seed) | 32'h1;
      wr(k, d);
      rdc(k, k[2] ? {16'h0, d[15:0]} : d);
    end
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTL, {20'h0, ctl_tab[i]});
      rdc(OFS_STAT, {20'h0, st_tab[i]});
    end
    rdc(OFS_CTL, 32'h0);
    xsize <= 2'($unsigned($random(seed)) % 3);
    a = $random(seed);
    b = $random(seed);
    @(posedge clk);
    s = stepb(xsize);
    wr(OFS_RX_ADDR, a);
    wr(OFS_RX_CNT, 32'h2);
    wr(OFS_RX_NADDR, b);
    wr(OFS_RX_NCNT, 32'h1);
    exp_q = '{a, a + s, b};
    wr(OFS_CTL, 32'h1);
    xfer(1'b1, 3);
    chk1(rx_end, 1'b1);
    chk1(rx_full, 1'b1);
    rdc(OFS_RX_ADDR, b + s);
    rdc(OFS_RX_CNT, 32'h0);
    rdc(OFS_RX_NCNT, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    @(negedge clk);
    chk1(irq, 1'b1);
    wr(OFS_RX_NCNT, 32'h0);
    @(negedge clk);
    chk1(rx_end, 1'b0);
    chk1(irq, 1'b0);
    wr(OFS_TX_ADDR, a);
    wr(OFS_TX_CNT, 32'h1);
    wr(OFS_TX_NCNT, 32'h0);
    exp_q = '{a};
    wr(OFS_CTL, 32'h100);
    wr(OFS_IRQ_MASK, 32'hC);
    xfer(1'b0, 1);
    tx_want <= 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk1(req, 1'b0);
    tx_want <= 1'b0;
    chk1(tx_end, 1'b1);
    chk1(tx_empty, 1'b1);
    chk1(irq, 1'b1);
    wr(OFS_IRQ_STAT, 32'h4);
    @(negedge clk);
    chk1(tx_end, 1'b0);
    chk1(irq, 1'b1);
    wr(OFS_IRQ_MASK, 32'h4);
    @(negedge clk);
    chk1(irq, 1'b0);
    chk1(hresp, 1'b0);
    close_out();
  end
endmodule // peripheral_dma_channel_regs_bench
